// ==== rtl/tap_pkg.sv ====
// shared types and constants for the sram boundary scan port
package tap_pkg;

    // -------------------------------------------------------------
    // controller states, gray coded along the usual walk
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR    = 4'h0,
        RTI    = 4'h1,
        SEL_DR = 4'h3,
        CAP_DR = 4'h2,
        SH_DR  = 4'h6,
        EX1_DR = 4'h7,
        PA_DR  = 4'h5,
        EX2_DR = 4'h4,
        UPD_DR = 4'hC,
        SEL_IR = 4'hD,
        CAP_IR = 4'hF,
        SH_IR  = 4'hE,
        EX1_IR = 4'hA,
        PA_IR  = 4'hB,
        EX2_IR = 4'h9,
        UPD_IR = 4'h8
    } tap_state_e;

    // -------------------------------------------------------------
    // instruction register
    // -------------------------------------------------------------
    localparam int         IR_W       = 3;
    localparam logic [2:0] I_EXTEST   = 3'h0;
    localparam logic [2:0] I_IDCODE   = 3'h1;
    localparam logic [2:0] I_SAMPLE_Z = 3'h2;
    localparam logic [2:0] I_RSV_A    = 3'h3;
    localparam logic [2:0] I_PRELOAD  = 3'h4;
    localparam logic [2:0] I_PRIVATE  = 3'h5;
    localparam logic [2:0] I_RSV_B    = 3'h6;
    localparam logic [2:0] I_BYPASS   = 3'h7;
    localparam logic [2:0] IR_RESET   = I_IDCODE;
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // data register selected between serial input and output
    typedef enum logic [1:0] {
        DR_BYP = 2'h0,
        DR_ID  = 2'h1,
        DR_BSR = 2'h3
    } dr_sel_e;

    // -------------------------------------------------------------
    // identification word layout
    // -------------------------------------------------------------
    localparam int         ID_W       = 32;
    localparam int         VEND_LSB   = 1;
    localparam int         VEND_W     = 11;
    localparam logic       ID_PRESENT = 1'h1;

    // -------------------------------------------------------------
    // reset values and counts
    // -------------------------------------------------------------
    localparam logic       PIN_IDLE   = 1'h1;
    localparam logic [2:0] TLR_ONES   = 3'h5;
    localparam int         EVT_DEPTH  = 4;

    // one sampled rising test clock edge
    typedef struct packed {
        logic tms;
        logic tdi;
    } tap_evt_s;

endpackage : tap_pkg

// ==== rtl/evt_fifo.sv ====
// small valid/ready fifo for sampled test clock events
`timescale 1ns/1ps
module evt_fifo #(
    parameter int W     = 2,
    parameter int DEPTH = 4
) (
    // system
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic          push;
    logic          pop;

    // honest full and empty from the fill count
    assign in_ready  = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
        end
    end

    // fill count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    fill_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
        cnt_r <= CW'(DEPTH))
        else $error("event fifo count beyond depth");

endmodule : evt_fifo

// ==== rtl/sram_boundary_scan_tap.sv ====
// boundary scan test access port of a synchronous burst sram
//
// Notes on behaviour
// - inputs on test clock rise, outputs on fall
// - mode select steers controller, floats high
// - data input feeds selected register, floats high
// - data output driven only while shifting
// - five ones on mode select resets controller
// - power-up reset, idle without test clock
// - every register shifts in rise, out fall
// - state plus instruction choose serial path
// - three bit instruction, loaded only when selected
// - reset state forces identification instruction
// - bypass is one flip-flop of delay
// - capture ring pins, then shift them out
// - pinless boundary positions capture one
// - boundary path only for three instructions
// - identification capture loads fixed 32-bit code
// - identification shifts out bit zero first
// - instruction capture loads low bits 01
// - instruction register shifts in, captured 001 out
// - new instruction acts only at update
// - instruction acts in idle and data states
// - decode extest, identification, preload, bypass
// - sample-z forces outputs off, boundary path
// - reserved codes behave as bypass
`timescale 1ns/1ps
module sram_boundary_scan_tap #(
    parameter int          PIN_W     = 48,
    parameter int          BSR_LEN   = 64,
    parameter logic [10:0] VENDOR_ID = 11'h2A5 // arbitrary value
) (
    // system
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // test port pins
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo_r,
    output logic                  tdo_oe_r,
    // ram i/o ring
    input  wire logic [PIN_W-1:0] ram_pins,
    output logic [PIN_W-1:0]      ram_drive_val_r,
    output logic                  ram_drive_en_r,
    output logic                  ram_hiz_r,
    // status
    output logic                  evt_overrun_r
);

    // -------------------------------------------------------------
    // decoding helpers
    // -------------------------------------------------------------

    // path chosen by the held instruction
    function automatic tap_pkg::dr_sel_e sel_dr(
        input logic [2:0] ir
    );
        case (ir)
            tap_pkg::I_EXTEST,
            tap_pkg::I_SAMPLE_Z,
            tap_pkg::I_PRELOAD: sel_dr = tap_pkg::DR_BSR;
            tap_pkg::I_IDCODE:  sel_dr = tap_pkg::DR_ID;
            default:            sel_dr = tap_pkg::DR_BYP;
        endcase
    endfunction : sel_dr

    // controller walk on one sampled mode select bit
    function automatic tap_pkg::tap_state_e next_st(
        input tap_pkg::tap_state_e s,
        input logic                m
    );
        case (s)
            tap_pkg::TLR:    next_st = m ? tap_pkg::TLR    : tap_pkg::RTI;
            tap_pkg::RTI:    next_st = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: next_st = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: next_st = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::SH_DR:  next_st = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::EX1_DR: next_st = m ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
            tap_pkg::PA_DR:  next_st = m ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
            tap_pkg::EX2_DR: next_st = m ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
            tap_pkg::UPD_DR: next_st = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_IR: next_st = m ? tap_pkg::TLR    : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: next_st = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::SH_IR:  next_st = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::EX1_IR: next_st = m ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
            tap_pkg::PA_IR:  next_st = m ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
            tap_pkg::EX2_IR: next_st = m ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
            tap_pkg::UPD_IR: next_st = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            default:         next_st = tap_pkg::TLR;
        endcase
    endfunction : next_st

    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------

    logic             tck_s1;
    logic             tck_s2;
    logic             tck_s3;
    logic             tms_s1;
    logic             tms_s2;
    logic             tdi_s1;
    logic             tdi_s2;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic             tck_rise;
    logic             tck_fall;

    // test pins idle high, as their pull-ups would hold them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tck_s1 <= tap_pkg::PIN_IDLE;
            tck_s2 <= tap_pkg::PIN_IDLE;
            tck_s3 <= tap_pkg::PIN_IDLE;
            tms_s1 <= tap_pkg::PIN_IDLE;
            tms_s2 <= tap_pkg::PIN_IDLE;
            tdi_s1 <= tap_pkg::PIN_IDLE;
            tdi_s2 <= tap_pkg::PIN_IDLE;
        end else begin
            tck_s1 <= tck;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= tms;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi;
            tdi_s2 <= tdi_s1;
        end
    end

    // ring pins change freely with the ram clock
    always_ff @(posedge clk_sys) begin
        pin_s1 <= ram_pins;
        pin_s2 <= pin_s1;
    end

    // edges seen only past the second stage
    assign tck_rise = tck_s2 & ~tck_s3;
    assign tck_fall = ~tck_s2 & tck_s3;

    // -------------------------------------------------------------
    // rising edge event queue
    // -------------------------------------------------------------

    tap_pkg::tap_evt_s evt_in;
    tap_pkg::tap_evt_s evt_out;
    logic              evt_rdy;
    logic              evt_vld;
    logic              fall_go_r;
    logic              pop;

    assign evt_in = '{tms: tms_s2, tdi: tdi_s2};
    // a pending fall is handled first; the queue holds rises meanwhile
    assign pop    = evt_vld & ~fall_go_r;

    evt_fifo #(
        .W     ($bits(tap_pkg::tap_evt_s)),
        .DEPTH (tap_pkg::EVT_DEPTH)
    ) u_evt_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (tck_rise),
        .in_ready  (evt_rdy),
        .in_data   (evt_in),
        .out_valid (evt_vld),
        .out_ready (~fall_go_r),
        .out_data  (evt_out)
    );

    // falling edge work waits one cycle behind detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fall_go_r <= 1'b0;
        end else begin
            fall_go_r <= tck_fall;
        end
    end

    // sticky flag when a rise finds the queue full
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evt_overrun_r <= 1'b0;
        end else if (tck_rise && !evt_rdy) begin
            evt_overrun_r <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // controller
    // -------------------------------------------------------------

    tap_pkg::tap_state_e state_r;
    tap_pkg::tap_state_e state_nxt;
    logic [2:0]          ones_r;

    assign state_nxt = next_st(state_r, evt_out.tms);

    // advance once per sampled rise; rst stands for power-up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= tap_pkg::TLR;
        end else if (pop) begin
            state_r <= state_nxt;
        end
    end

    // run of consecutive high mode select samples
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ones_r <= '0;
        end else if (pop) begin
            if (!evt_out.tms) begin
                ones_r <= '0;
            end else if (ones_r != tap_pkg::TLR_ONES) begin
                ones_r <= ones_r + 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // instruction register
    // -------------------------------------------------------------

    logic [2:0]        ir_r;
    logic [2:0]        ir_sh_r;
    logic              upd_ir_go;
    tap_pkg::dr_sel_e  dsel;

    assign upd_ir_go = fall_go_r & (state_r == tap_pkg::UPD_IR);
    assign dsel      = sel_dr(ir_r);

    // capture and shift stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ir_sh_r <= tap_pkg::IR_RESET;
        end else if (pop && state_r == tap_pkg::CAP_IR) begin
            ir_sh_r <= tap_pkg::IR_CAPTURE;
        end else if (pop && state_r == tap_pkg::SH_IR) begin
            ir_sh_r <= {evt_out.tdi, ir_sh_r[2:1]};
        end
    end

    // held instruction changes only at update or reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ir_r <= tap_pkg::IR_RESET;
        end else if (pop && state_nxt == tap_pkg::TLR) begin
            ir_r <= tap_pkg::IR_RESET;
        end else if (upd_ir_go) begin
            ir_r <= ir_sh_r;
        end
    end

    // -------------------------------------------------------------
    // data registers
    // -------------------------------------------------------------

    logic                        byp_r;
    logic [tap_pkg::ID_W-1:0]    id_sh_r;
    logic [tap_pkg::ID_W-1:0]    id_word;
    logic [BSR_LEN-1:0]          bsr_sh_r;
    logic [BSR_LEN-1:0]          cap_vec;
    logic                        id_lsb;

    // fixed code: upper bits unused, vendor field, presence bit
    always_comb begin
        id_word = '0;
        id_word[tap_pkg::VEND_LSB +: tap_pkg::VEND_W] = VENDOR_ID;
        id_word[0] = tap_pkg::ID_PRESENT;
    end

    // pin positions take ring levels, the rest read one
    for (genvar i = 0; i < BSR_LEN; i++) begin : g_cap
        if (i < PIN_W) begin : g_pin
            assign cap_vec[i] = pin_s2[i];
        end else begin : g_hold
            assign cap_vec[i] = 1'b1;
        end
    end

    // bypass bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            byp_r <= 1'b0;
        end else if (pop && dsel == tap_pkg::DR_BYP) begin
            if (state_r == tap_pkg::CAP_DR) begin
                byp_r <= 1'b0;
            end else if (state_r == tap_pkg::SH_DR) begin
                byp_r <= evt_out.tdi;
            end
        end
    end

    // identification register, shifts toward bit zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            id_sh_r <= '0;
        end else if (pop && dsel == tap_pkg::DR_ID) begin
            if (state_r == tap_pkg::CAP_DR) begin
                id_sh_r <= id_word;
            end else if (state_r == tap_pkg::SH_DR) begin
                id_sh_r <= {evt_out.tdi, id_sh_r[31:1]};
            end
        end
    end

    // boundary register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bsr_sh_r <= '0;
        end else if (pop && dsel == tap_pkg::DR_BSR) begin
            if (state_r == tap_pkg::CAP_DR) begin
                bsr_sh_r <= cap_vec;
            end else if (state_r == tap_pkg::SH_DR) begin
                bsr_sh_r <= {evt_out.tdi, bsr_sh_r[BSR_LEN-1:1]};
            end
        end
    end

    assign id_lsb = id_sh_r[0];

    // -------------------------------------------------------------
    // serial output and ring drive
    // -------------------------------------------------------------

    logic shifting;
    logic out_bit;

    assign shifting = (state_r == tap_pkg::SH_DR)
                    | (state_r == tap_pkg::SH_IR);

    // outgoing bit of the register on the path
    always_comb begin
        out_bit = byp_r;
        if (state_r == tap_pkg::SH_IR) begin
            out_bit = ir_sh_r[0];
        end else if (dsel == tap_pkg::DR_ID) begin
            out_bit = id_sh_r[0];
        end else if (dsel == tap_pkg::DR_BSR) begin
            out_bit = bsr_sh_r[0];
        end
    end

    // launch on the falling edge only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (fall_go_r) begin
            tdo_oe_r <= shifting;
            if (shifting) begin
                tdo_r <= out_bit;
            end
        end
    end

    // boundary contents reach the output ring at update
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ram_drive_val_r <= '0;
        end else if (fall_go_r && state_r == tap_pkg::UPD_DR
                     && dsel == tap_pkg::DR_BSR) begin
            ram_drive_val_r <= bsr_sh_r[PIN_W-1:0];
        end
    end

    // ring control follows the held instruction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ram_drive_en_r <= 1'b0;
            ram_hiz_r      <= 1'b0;
        end else begin
            ram_drive_en_r <= (ir_r == tap_pkg::I_EXTEST);
            ram_hiz_r      <= (ir_r == tap_pkg::I_SAMPLE_Z);
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    five_ones_a: assert property (
        ones_r == tap_pkg::TLR_ONES |-> state_r == tap_pkg::TLR)
        else $error("five high samples did not reach reset state");

    reset_instr_a: assert property (
        state_r == tap_pkg::TLR |-> ir_r == tap_pkg::IR_RESET)
        else $error("reset state without identification instruction");

    instr_update_a: assert property (
        $changed(ir_r) |-> state_r == tap_pkg::TLR || $past(upd_ir_go))
        else $error("instruction changed outside update");

    tdo_on_fall_a: assert property (
        $changed(tdo_oe_r) || $changed(tdo_r) |-> $past(fall_go_r))
        else $error("serial output moved without a falling edge");

    tdo_enable_a: assert property (
        fall_go_r |=> tdo_oe_r == $past(shifting))
        else $error("serial output enable not tied to shift state");

    ir_capture_a: assert property (
        pop && state_r == tap_pkg::CAP_IR |=> ir_sh_r[1:0] == 2'h1)
        else $error("instruction capture pattern wrong");

    id_capture_a: assert property (
        pop && state_r == tap_pkg::CAP_DR && dsel == tap_pkg::DR_ID
        |=> id_sh_r == id_word)
        else $error("identification capture wrong");

    id_lsb_out_a: assert property (
        fall_go_r && state_r == tap_pkg::SH_DR && dsel == tap_pkg::DR_ID
        |=> tdo_r == $past(id_lsb))
        else $error("identification bit order wrong");

    bypass_delay_a: assert property (
        fall_go_r && state_r == tap_pkg::SH_DR && dsel == tap_pkg::DR_BYP
        |=> tdo_r == $past(byp_r))
        else $error("bypass path not one flop");

    hiz_force_a: assert property (
        ir_r == tap_pkg::I_SAMPLE_Z |=> ram_hiz_r)
        else $error("sample-z did not force high impedance");

endmodule : sram_boundary_scan_tap

// ==== tb/jtag_host.sv ====
// test controller model that drives the boundary scan link
`timescale 1ns/1ps
module jtag_host (
    // link pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // ----------------------------------------------------------
    // idle link: clock low, floating inputs read as one
    // ----------------------------------------------------------
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one period: pins set in low phase, tdo taken just before rise
    task automatic step(input logic m, input logic d, output logic [1:0] o);
        tms = m;
        tdi = d;
        #125;
        o   = {tdo_oe, tdo};
        tck = 1'b1;
        #75;
        tck = 1'b0;
    endtask : step

    // five ones reach reset from anywhere, then park in idle
    task automatic tlr();
        logic [1:0] o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask : tlr

    // walk to shift-ir and send a new code, the captured 001 pattern comes out
    task automatic ir_shift(input logic [2:0] c, output logic [2:0] q);
        logic [1:0] o;
        step(1'b1, 1'b1, o);
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < 3; i++) begin
            step(i == 2, c[i], o);
            // a released output reads as the inverse of its last level
            q[i] = o[1] ? o[0] : ~o[0];
        end
    endtask : ir_shift

    // leave exit1-ir through update back to idle
    task automatic ir_update();
        logic [1:0] o;
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask : ir_update

    // capture, shift 64 bits lsb first, update, back to idle
    task automatic dr_shift(input logic [63:0] d, output logic [63:0] q,
                            output logic oe);
        logic [1:0] o;
        oe = 1'b1;
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < 64; i++) begin
            step(i == 63, d[i], o);
            q[i] = o[0];
            oe   = oe & o[1];
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask : dr_shift
endmodule : jtag_host

// ==== tb/tb.sv ====
// self-checking bench for the sram boundary scan port
`timescale 1ns/1ps
module tb;
    localparam logic [10:0] VEND = 11'h4C3; // arbitrary value
    logic        clk_sys;
    logic        rst;
    logic        tck, tms, tdi, tdo_r, tdo_oe_r;
    logic        ram_drive_en_r, ram_hiz_r, evt_overrun_r, oe_all;
    logic [47:0] ram_pins, ram_drive_val_r;
    logic [63:0] din, dout;
    logic [2:0]  cur, irv, q3;
    logic [1:0]  ob;
    int          err_count, checks_done;

    // ----------------------------------------------------------
    // design, link partner and clock
    // ----------------------------------------------------------
    sram_boundary_scan_tap #(.PIN_W(48), .BSR_LEN(64), .VENDOR_ID(VEND)) uut (
        .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r), .ram_pins(ram_pins),
        .ram_drive_val_r(ram_drive_val_r), .ram_drive_en_r(ram_drive_en_r),
        .ram_hiz_r(ram_hiz_r), .evt_overrun_r(evt_overrun_r));
    jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_r),
                    .tdo_oe(tdo_oe_r));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------
    // expectations and comparison
    // ----------------------------------------------------------
    function automatic logic [63:0] exp_dr(input logic [2:0] c,
                                           input logic [47:0] p,
                                           input logic [63:0] d);
        case (c)
            tap_pkg::I_EXTEST, tap_pkg::I_SAMPLE_Z,
            tap_pkg::I_PRELOAD: return {16'hFFFF, p};
            tap_pkg::I_IDCODE:  return {d[31:0], 20'h0, VEND, 1'b1};
            default:            return {d[62:0], 1'b0};
        endcase
    endfunction : exp_dr

    // ring control pair {drive enable, high-z} for a held code
    function automatic logic [1:0] exp_ring(input logic [2:0] c);
        return {c == tap_pkg::I_EXTEST, c == tap_pkg::I_SAMPLE_Z};
    endfunction : exp_ring

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // watchdog well beyond the expected run length
    initial begin
        #1000000;
        err_count++;
        end_of_test();
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        rst         = 1'b1;
        ram_pins    = 48'h0;
        err_count   = 0;
        checks_done = 0;
        void'($urandom(53599));
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (40) @(negedge clk_sys);
        chk({tdo_oe_r, ram_drive_en_r, ram_hiz_r}, 64'h0);
        host.tlr();
        cur = tap_pkg::I_IDCODE;
        // every code once, then random codes; random pin levels throughout
        for (int k = 0; k < 13; k++) begin
            irv = (k < 8) ? k[2:0] : 3'($urandom % 8);
            @(negedge clk_sys);
            ram_pins = {16'($urandom), $urandom};
            din      = {$urandom, $urandom};
            host.ir_shift(irv, q3);
            chk(q3, 3'b001);
            chk({ram_drive_en_r, ram_hiz_r}, exp_ring(cur));
            host.ir_update();
            cur = irv;
            chk({ram_drive_en_r, ram_hiz_r}, exp_ring(cur));
            host.dr_shift(din, dout, oe_all);
            chk(dout, exp_dr(cur, ram_pins, din));
            chk({oe_all, tdo_oe_r}, 2'b10);
            if (cur == tap_pkg::I_EXTEST)
                chk(ram_drive_val_r, din[47:0]);
        end
        // abort a data shift under extest by five ones
        host.ir_shift(tap_pkg::I_EXTEST, q3);
        host.ir_update();
        host.step(1'b1, 1'b1, ob);
        repeat (6) host.step(1'b0, 1'b1, ob);
        chk(ob, {1'b1, ram_pins[3]});
        host.tlr();
        chk({ram_drive_en_r, ram_hiz_r, tdo_oe_r}, 64'h0);
        host.dr_shift(din, dout, oe_all);
        chk(dout, exp_dr(tap_pkg::I_IDCODE, ram_pins, din));
        chk(evt_overrun_r, 64'h0);
        end_of_test();
    end
endmodule : tb
